// *** rtl/ipr_map.svh ***
// Purpose: offsets, field positions, reset values for the upper priority bank
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes: register data is 16 bits wide, upper half reads zero
`ifndef IPR_MAP_SVH
`define IPR_MAP_SVH

// register byte offsets
`define IPR_OFF_EXT34 6'h00
`define IPR_OFF_CAL 6'h04
`define IPR_OFF_CRCSER 6'h08
`define IPR_OFF_LOWV 6'h0C
`define IPR_OFF_TMEAS 6'h10
`define IPR_OFF_SER3 6'h14
`define IPR_OFF_SER4TW3 6'h18

// field low-bit positions inside a register
`define IPR_POS_HI 12
`define IPR_POS_MID 8
`define IPR_POS_LO4 4
`define IPR_POS_LO0 0

// reset level of every field
`define IPR_LEVEL_RESET 3'h4
// disabled level
`define IPR_LEVEL_OFF 3'h0

// axi response codes
`define IPR_RESP_OKAY 2'h0
`define IPR_RESP_SLVERR 2'h2

`endif

// *** rtl/ipr_pkg.sv ***
// Purpose: types for the upper priority bank
// Assumes: nothing beyond the map header
// Notes: fields are 3-bit levels, 0 means the source is off
package ipr_pkg;

    // one priority level, 0 off, 1 lowest, 7 highest
    typedef logic [2:0] ipr_level_t;

    // all fourteen priority fields of the bank
    typedef struct packed {
        ipr_level_t ext_irq_four_level;
        ipr_level_t ext_irq_three_level;
        ipr_level_t calendar_clock_level;
        ipr_level_t checksum_error_level;
        ipr_level_t serial_two_error_level;
        ipr_level_t serial_one_error_level;
        ipr_level_t low_voltage_level;
        ipr_level_t time_measure_level;
        ipr_level_t serial_three_transmit_level;
        ipr_level_t serial_three_receive_level;
        ipr_level_t serial_three_error_level;
        ipr_level_t serial_four_error_level;
        ipr_level_t twowire_three_master_level;
        ipr_level_t twowire_three_slave_level;
    } ipr_fields_t;

    // one enable-qualified bit per source, same order as the fields
    typedef logic [13:0] ipr_src_vec_t;

    // whole module state
    typedef struct packed {
        ipr_fields_t f;
        logic bvalid;
        logic rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] awaddr;
        logic aw_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_held;
    } ipr_state_t;

endpackage

// *** rtl/ipr_regs.sv ***
// Purpose: AXI4-Lite bank of 3-bit interrupt priority fields, upper group
// Assumes: one clock, synchronous active-low reset, single outstanding access
// Notes: levels leave as ports to arbitration logic outside this block
//
// What this block does
// - each field is 3 bits, 7 highest
// - level 0 disables its source request
// - level 1 is lowest enabled priority
// - unassigned bits ignore writes, read zero
// - fields read back last written value
// - ext irq four at bits 10:8
// - ext irq three at bits 6:4
// - calendar clock at 10:8, rest unused
// - checksum error at bits 14:12
// - serial two error 10:8, one 6:4
// - low voltage at 2:0, 15:3 unused
// - time measure at 6:4, rest unused
// - serial three tx 14:12, rx 10:8, err 6:4
// - serial four error 14:12, 11:7 unused
// - twowire three master 6:4, slave 2:0
// - every field resets to level four
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`include "ipr_map.svh"

// register map, one aligned 32-bit word per register:
//   0x00 external irq four and three
//   0x04 calendar clock
//   0x08 checksum error, serial two error, serial one error
//   0x0C low voltage
//   0x10 time measure unit
//   0x14 serial three transmit, receive and error
//   0x18 serial four error, twowire three master and slave
// each field is a 3-bit level sitting in a nibble whose top bit is unused,
// so a register word is just the levels written with a zero spacer bit
//
// bus behaviour in short:
//   - write address and write data are taken in either order
//   - whichever arrives first is parked until its partner shows up
//   - the response is registered and rises one edge after both are in
//   - only one write response may be outstanding; new halves wait
//   - a read is answered one edge after its address is taken
//   - read data stands until the master takes it with rready
//
// limitations a user must know:
//   - strobes 3:2 are ignored because the upper half has no storage
//   - an address outside the seven words answers with an error
//   - misaligned offsets never decode, even if inside the window
//   - no wait states beyond the single registered response cycle
//
// why levels leave as a plain bus:
//   the arbiter outside needs every level every cycle; a registered copy
//   would add a cycle of lag between a write and the arbitration result,
//   so the levels come straight from the storage flip-flops
//
// why src_request sits here:
//   level zero is the one value that changes behaviour inside this block;
//   gating the flags here keeps a disabled source from ever reaching the
//   arbiter, whatever its flag does, without the arbiter decoding zero
//
// reset:
//   synchronous and active low; every field comes up at level four and
//   both response channels come up idle, so the first request may be
//   offered at the first edge after release

module ipr_regs
    import ipr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // raw flags of the fourteen sources, in field order
    input wire ipr_src_vec_t src_flag,
    // current levels for the arbiter
    output ipr_fields_t levels,
    // flags passed on only where the level is non-zero
    output ipr_src_vec_t src_request
);

    ipr_state_t st_r;  // registered state
    ipr_state_t st_nxt;  // next state
    logic wr_go;  // address and data each held or valid now, no response pending
    logic [31:0] wa;  // effective write address
    logic [31:0] wd;  // effective write data
    logic [3:0] ws;  // effective strobes
    logic [15:0] wmask;  // 16-bit lane mask from strobes
    logic [15:0] rd16;  // read mux result
    logic rd_hit;  // read address decodes
    logic wr_hit;  // write address decodes
    ipr_level_t lv [14];  // levels as an array for the request gate

    // register file view of the fields
    function automatic logic [15:0] put3(input ipr_level_t v, input int pos);
        logic [15:0] r;
        r = 16'h0000;
        r[pos +: 3] = v;
        return r;
    endfunction

    // merge only strobed bits of a field from new data
    function automatic ipr_level_t upd(input ipr_level_t old, input logic [15:0] d,
                                       input logic [15:0] m, input int pos);
        ipr_level_t r;
        r = (old & ~m[pos +: 3]) | (d[pos +: 3] & m[pos +: 3]);
        return r;
    endfunction

    assign wmask = {{8{ws[1]}}, {8{ws[0]}}};

    // address and data may arrive in either order; hold each until both are in
    assign wa = st_r.aw_held ? st_r.awaddr : s_axi_awaddr;
    assign wd = st_r.w_held ? st_r.wdata : s_axi_wdata;
    assign ws = st_r.w_held ? st_r.wstrb : s_axi_wstrb;
    assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
    assign wr_go = !st_r.bvalid && (st_r.aw_held || s_axi_awvalid)
                   && (st_r.w_held || s_axi_wvalid);
    // a new read is taken only when no read data is waiting
    assign s_axi_arready = !st_r.rvalid;

    // read decode; every unassigned bit is zero by construction
    always_comb
    begin
        rd16 = 16'h0000;
        rd_hit = 1'b1;
        case (s_axi_araddr[5:0])
            `IPR_OFF_EXT34:
            begin
                rd16 = put3(st_r.f.ext_irq_four_level, `IPR_POS_MID)
                     | put3(st_r.f.ext_irq_three_level, `IPR_POS_LO4);
            end
            `IPR_OFF_CAL:
                rd16 = put3(st_r.f.calendar_clock_level, `IPR_POS_MID);
            `IPR_OFF_CRCSER:
            begin
                rd16 = put3(st_r.f.checksum_error_level, `IPR_POS_HI)
                     | put3(st_r.f.serial_two_error_level, `IPR_POS_MID)
                     | put3(st_r.f.serial_one_error_level, `IPR_POS_LO4);
            end
            `IPR_OFF_LOWV:
                rd16 = put3(st_r.f.low_voltage_level, `IPR_POS_LO0);
            `IPR_OFF_TMEAS:
                rd16 = put3(st_r.f.time_measure_level, `IPR_POS_LO4);
            `IPR_OFF_SER3:
            begin
                rd16 = put3(st_r.f.serial_three_transmit_level, `IPR_POS_HI)
                     | put3(st_r.f.serial_three_receive_level, `IPR_POS_MID)
                     | put3(st_r.f.serial_three_error_level, `IPR_POS_LO4);
            end
            `IPR_OFF_SER4TW3:
            begin
                rd16 = put3(st_r.f.serial_four_error_level, `IPR_POS_HI)
                     | put3(st_r.f.twowire_three_master_level, `IPR_POS_LO4)
                     | put3(st_r.f.twowire_three_slave_level, `IPR_POS_LO0);
            end
            default:
                rd_hit = 1'b0;
        endcase
        // only word-aligned offsets inside the low window decode
        if (s_axi_araddr[31:6] != 26'h0000000)
        begin
            rd_hit = 1'b0;
            rd16 = 16'h0000;
        end
    end

    // write decode check
    always_comb
    begin
        case (wa[5:0])
            `IPR_OFF_EXT34, `IPR_OFF_CAL, `IPR_OFF_CRCSER, `IPR_OFF_LOWV,
            `IPR_OFF_TMEAS, `IPR_OFF_SER3, `IPR_OFF_SER4TW3:
                wr_hit = (wa[31:6] == 26'h0000000);
            default:
                wr_hit = 1'b0;
        endcase
    end

    // write sequencing, by cycle:
    //   edge n   : address and data both present, no response pending
    //              -> fields updated, bvalid set for the next cycle
    //   edge n+1 : bvalid seen high by the master; with bready it retires
    //   edge n+2 : awready and wready high again for the next write
    // a half that arrives alone is parked in aw_held or w_held and its
    // ready drops, so the master sees it taken and may release it
    //
    // hazard: parking and completing in the same cycle would double-take a
    // half, so the parking branches are skipped whenever wr_go is true
    //
    // trade-off: no write buffering; a second write stalls while the
    // first response is outstanding, which keeps the response order simple
    //
    // read sequencing, by cycle:
    //   edge n   : arvalid with arready -> rdata and rresp registered
    //   edge n+1 : rvalid high; with rready it retires
    //   edge n+2 : arready high again
    // retire and new capture are ordered so a capture always wins, though
    // arready low while rvalid means both never fall in one cycle
    //
    // next-state logic for bus handshakes and field storage
    always_comb
    begin
        st_nxt = st_r;
        // capture whichever half of a write arrives first
        if (!wr_go && s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (!wr_go && s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (wr_go)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_hit ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
            // only field bits take data; the rest of the word is dropped
            case (wr_hit ? wa[5:0] : 6'h3F)
                `IPR_OFF_EXT34:
                begin
                    st_nxt.f.ext_irq_four_level =
                        upd(st_r.f.ext_irq_four_level, wd[15:0], wmask, `IPR_POS_MID);
                    st_nxt.f.ext_irq_three_level =
                        upd(st_r.f.ext_irq_three_level, wd[15:0], wmask, `IPR_POS_LO4);
                end
                `IPR_OFF_CAL:
                    st_nxt.f.calendar_clock_level =
                        upd(st_r.f.calendar_clock_level, wd[15:0], wmask, `IPR_POS_MID);
                `IPR_OFF_CRCSER:
                begin
                    st_nxt.f.checksum_error_level =
                        upd(st_r.f.checksum_error_level, wd[15:0], wmask, `IPR_POS_HI);
                    st_nxt.f.serial_two_error_level =
                        upd(st_r.f.serial_two_error_level, wd[15:0], wmask, `IPR_POS_MID);
                    st_nxt.f.serial_one_error_level =
                        upd(st_r.f.serial_one_error_level, wd[15:0], wmask, `IPR_POS_LO4);
                end
                `IPR_OFF_LOWV:
                    st_nxt.f.low_voltage_level =
                        upd(st_r.f.low_voltage_level, wd[15:0], wmask, `IPR_POS_LO0);
                `IPR_OFF_TMEAS:
                    st_nxt.f.time_measure_level =
                        upd(st_r.f.time_measure_level, wd[15:0], wmask, `IPR_POS_LO4);
                `IPR_OFF_SER3:
                begin
                    st_nxt.f.serial_three_transmit_level =
                        upd(st_r.f.serial_three_transmit_level, wd[15:0], wmask, `IPR_POS_HI);
                    st_nxt.f.serial_three_receive_level =
                        upd(st_r.f.serial_three_receive_level, wd[15:0], wmask, `IPR_POS_MID);
                    st_nxt.f.serial_three_error_level =
                        upd(st_r.f.serial_three_error_level, wd[15:0], wmask, `IPR_POS_LO4);
                end
                `IPR_OFF_SER4TW3:
                begin
                    st_nxt.f.serial_four_error_level =
                        upd(st_r.f.serial_four_error_level, wd[15:0], wmask, `IPR_POS_HI);
                    st_nxt.f.twowire_three_master_level =
                        upd(st_r.f.twowire_three_master_level, wd[15:0], wmask, `IPR_POS_LO4);
                    st_nxt.f.twowire_three_slave_level =
                        upd(st_r.f.twowire_three_slave_level, wd[15:0], wmask, `IPR_POS_LO0);
                end
                default:
                    st_nxt.f = st_r.f;  // unmapped: nothing stored, error returned
            endcase
        end
        // response retires when the master takes it
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        // read: data registered on the same edge that takes the address
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = {16'h0000, rd16};
            st_nxt.rresp = rd_hit ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
        end
    end

    // the whole state lives in one packed struct so that reset and update
    // cover every bit in one place; nothing in it escapes the reset
    //
    // reset clears handshake state to idle first, then loads the fields;
    // the later assignment wins for the field bits only
    //
    // state register; fields come up at level four
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.f <= {14{`IPR_LEVEL_RESET}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

    // full 3-bit level goes out: 7 highest, 1 lowest, middle ordered by value
    assign levels = st_r.f;

    // unpack levels, msb field first, to match src_flag bit 13 down to 0
    always_comb
    begin
        for (int i = 0; i < 14; i++)
        begin
            lv[i] = st_r.f[i*3 +: 3];
        end
    end

    // the request gate is purely combinational: a level written to zero
    // silences its source from the same cycle in which the write response rises,
    // with no extra latency, since the arbiter samples on the same clock
    //
    // flags are expected from logic on this clock; an asynchronous flag
    // would need its own synchroniser before it reaches this port
    //
    // a source at level zero never requests, whatever its flag
    always_comb
    begin
        for (int i = 0; i < 14; i++)
        begin
            src_request[i] = src_flag[i] && (lv[i] != `IPR_LEVEL_OFF);
        end
    end

endmodule

// *** sim/ipr_regs_props.sv ***
// Purpose: bus and level checks on the priority bank ports
// Assumes: single clock, sync active-low reset
// Notes: bound into every ipr_regs instance
module ipr_regs_props
    import ipr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ipr_src_vec_t src_flag,
    input wire ipr_fields_t levels,
    input wire ipr_src_vec_t src_request
);
    logic [41:0] lv; // flat copy of the fields
    logic [13:0] req_exp; // flag gated by a non-zero level
    assign lv = levels;
    // field i sits at lv[3i+2:3i], first field highest
    always_comb
    begin
        for (int i = 0; i < 14; i++)
            req_exp[i] = src_flag[i] & (|lv[3*i +: 3]);
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_req_gating: assert property (src_request == req_exp)
        else $error("request gating wrong");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("no write answer");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_levels_quiet: assert property (!$rose(s_axi_bvalid) |-> $stable(levels))
        else $error("level moved without write");
endmodule

bind ipr_regs ipr_regs_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_flag(src_flag), .levels(levels),
    .src_request(src_request));

// *** sim/tb_top.sv ***
// Purpose: directed register tests of the priority bank
// Assumes: axi4-lite master in this bench, 50 MHz clock
// Notes: expected words come from the field map below
module tb_top;
    import ipr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, r;
    logic [31:0] d;
    ipr_src_vec_t src_flag = '1, src_request;
    ipr_fields_t levels;
    int check_count = 0, n_mismatch = 0;
    // offset, reset word and implemented bits per register
    logic [31:0] offs [7] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h10, 32'h14, 32'h18};
    logic [15:0] rstw [7] = '{16'h0440, 16'h0400, 16'h4440, 16'h0004, 16'h0040,
        16'h4440, 16'h4044};
    logic [15:0] mask [7] = '{16'h0770, 16'h0700, 16'h7770, 16'h0007, 16'h0070,
        16'h7770, 16'h7077};
    ipr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_flag(src_flag), .levels(levels),
        .src_request(src_request));
    always #10 aclk = ~aclk;
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end
        while (bvalid !== 1'b1 && n < 100);
        // a write that never answers is a failure, not a silent pass
        if (n >= 100) n_mismatch++;
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end
        while (rvalid !== 1'b1 && n < 100);
        // a read that never answers is a failure, not a silent pass
        if (n >= 100) n_mismatch++;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // second reset after all-ones contents must restore level four
    task automatic test_reset();
        do_reset();
        `CHK("levels", {14{3'h4}}, levels)
        for (int i = 0; i < 7; i++)
        begin
            rd(offs[i]);
            `CHK("rst word", {16'h0, rstw[i]}, d)
        end
        $display("test_reset done");
    endtask
    // only field bits store; all else reads zero
    task automatic test_ones();
        for (int i = 0; i < 7; i++)
        begin
            wr(offs[i], 32'hFFFFFFFF, 4'hF);
            `CHK("wr resp", 2'h0, r)
            rd(offs[i]);
            `CHK("ones word", {16'h0, mask[i]}, d)
            `CHK("rd resp", 2'h0, r)
        end
        `CHK("all seven", {14{3'h7}}, levels)
        `CHK("requests", 14'h3FFF, src_request)
        $display("test_ones done");
    endtask
    // every code 0..7 through two registers
    task automatic test_levels();
        logic [31:0] v;
        for (int i = 0; i < 8; i++)
        begin
            v = 32'(i);
            wr(32'h00, (v << 8) | (v << 4), 4'hF);
            `CHK("ext four", v[2:0], levels.ext_irq_four_level)
            `CHK("ext three", v[2:0], levels.ext_irq_three_level)
            `CHK("req 13", i != 0, src_request[13])
            wr(32'h18, (v << 12) | (v << 4) | v, 4'hF);
            `CHK("ser4 err", v[2:0], levels.serial_four_error_level)
            `CHK("tw3 mst", v[2:0], levels.twowire_three_master_level)
            `CHK("tw3 slv", v[2:0], levels.twowire_three_slave_level)
            `CHK("req 0", i != 0, src_request[0])
        end
        src_flag <= '0;
        @(posedge aclk);
        `CHK("no flags", 14'h0, src_request)
        src_flag <= '1;
        $display("test_levels done");
    endtask
    // byte strobes select the bytes written
    task automatic test_strobe();
        wr(32'h0C, 32'h5, 4'hF);
        wr(32'h0C, 32'h2, 4'h2);
        rd(32'h0C);
        `CHK("strobe hi", 32'h5, d)
        wr(32'h08, 32'h3333, 4'h1);
        rd(32'h08);
        `CHK("strobe lo", 32'h4430, d)
        $display("test_strobe done");
    endtask
    // address first, data on the next edge: the held-address path
    task automatic test_split();
        @(posedge aclk);
        awaddr <= 32'h10;
        awvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wdata <= 32'h60;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        `CHK("split resp", 2'h0, r)
        `CHK("split lvl", 3'h6, levels.time_measure_level)
        rd(32'h10);
        `CHK("split word", 32'h60, d)
        $display("test_split done");
    endtask
    task automatic test_unmapped();
        logic [31:0] a [2] = '{32'h1C, 32'h100};
        for (int i = 0; i < 2; i++)
        begin
            wr(a[i], 32'h7777, 4'hF);
            `CHK("bad wr", 2'h2, r)
            rd(a[i]);
            `CHK("bad rd", 2'h2, r)
            `CHK("bad data", 32'h0, d)
        end
        $display("test_unmapped done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        #400000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        do_reset();
        test_ones();
        test_reset();
        test_levels();
        test_strobe();
        test_split();
        test_unmapped();
        complete_run();
    end
endmodule
